// File: rtl/tcm_pkg.sv
// Purpose: Constants shared by the timer channel mode control block.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Offsets are byte addresses.
package tcm_pkg;
  // ****************************************************************
  // Bus
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_PRESC = 8'h04;
  localparam logic [7:0] OFF_CMP = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_CNT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int MODE_CKS_HI = 15;
  localparam int MODE_CKS_LO = 14;
  localparam int MODE_CCS = 12;
  localparam int MODE_MD_HI = 3;
  localparam int MODE_MD_LO = 1;
  localparam int MODE_OPT = 0;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [2:0] MD_INTERVAL = 3'h0;
  localparam logic [2:0] MD_CAPTURE = 3'h2;
  localparam logic [2:0] MD_EVENT = 3'h3;
  localparam logic [2:0] MD_ONECOUNT = 3'h4;
  localparam logic [2:0] MD_CAP_ONE = 3'h6;
  // ****************************************************************
  // Prescaler, control and interrupt fields
  // ****************************************************************
  localparam int PRESC_N = 4;
  localparam int PRESC_CODE_W = 4;
  localparam logic [15:0] PRESC_RESET = 16'h0000;
  localparam int CTRL_UNIT_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_OUT_EN = 3;
  localparam int CTRL_OUT_LVL = 4;
  localparam int CTRL_RUNNING = 5;
  localparam int IRQ_N = 2;
  localparam int IRQ_TIMER = 0;
  localparam int IRQ_BAD_MODE = 1;
endpackage : tcm_pkg

// File: rtl/tcm_top.sv
// Purpose: One timer channel with mode, clock selection, prescaler and AXI4-Lite registers.
// Assumes: Single clock aclk, synchronous active-low reset, software start and stop.
// Notes: Start-trigger and capture-edge fields are stored but not decoded; the input's rising edge is used.

// Contract
// - Clock select codes 00,01,10,11 pick prescaler outputs 0,2,1,3.
// - Count clock source 0 counts operation clock, 1 counts input pin edges.
// - Mode 0110 is event counter, counting down, no start interrupt.
// - Mode 100 is one-count, counting down.
// - Mode 1100 is capture plus one-count, counting up; other codes prohibited (the code also accepts 0111 and 1101).
// - Interval or capture with option 0: no interrupt or output change at start.
// - Interval or capture with option 1: interrupt and output change at start.
// - One-count with option 0 ignores start triggers while counting.
// - One-count with option 1 restarts on a start trigger, no interrupt.
// - Capture plus one-count: no start interrupt, start triggers ignored while counting.
// - Each prescaler output divides the clock by two to a four-bit code.
// - Interval mode interrupts every compare value plus one count periods.
// - Output enable 1 lets the timer drive output; 0 keeps software value.
module tcm_top
  import tcm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // Write data channel
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Write response channel
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Read address channel
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // Read data channel
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Timer pins
  input wire logic timer_input_pin,
  output logic timer_output,
  output logic channel_interrupt
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] prescale;
    logic [CNT_W-1:0] compare;
    logic [CNT_W-1:0] counter;
    logic unit_en;
    logic out_en;
    logic out_lvl;
    logic running;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_en;
    logic irq;
    logic [2:0] pin_sync;
    logic pin_lvl;
    logic [15:0] div;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_rdy;
    logic w_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tcm_state_type;

  tcm_state_type state_q;
  tcm_state_type state_d;
  logic [PRESC_N-1:0] presc_tick;

  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 2 and 16");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ****************************************************************
  // Prescaler outputs
  // ****************************************************************
  // Each output ticks once every two-to-the-code clocks; code zero ticks every clock.
  for (genvar i = 0; i < PRESC_N; i++) begin : g_presc
    logic [PRESC_CODE_W-1:0] code;
    logic [15:0] mask;
    assign code = state_q.prescale[i*PRESC_CODE_W +: PRESC_CODE_W];
    assign mask = (16'h0001 << code) - 16'h0001;
    assign presc_tick[i] = state_q.unit_en && ((state_q.div & mask) == mask);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [2:0] md;
    logic opt;
    logic mode_ok;
    logic up_mode;
    logic op_tick;
    logic cnt_tick;
    logic pin_edge;
    logic start;
    logic stop;
    logic ev_timer;
    logic ev_bad;
    logic toggle;
    logic [15:0] wv;
    md = state_q.mode[MODE_MD_HI:MODE_MD_LO];
    opt = state_q.mode[MODE_OPT];
    mode_ok = 1'b0;
    up_mode = 1'b0;
    op_tick = 1'b0;
    cnt_tick = 1'b0;
    pin_edge = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    ev_timer = 1'b0;
    ev_bad = 1'b0;
    toggle = 1'b0;
    wv = 16'h0000;
    state_d = state_q;

    // Input pin: a new level is taken once the second and third stages agree.
    state_d.pin_sync = {state_q.pin_sync[1:0], timer_input_pin};
    if (state_q.pin_sync[1] == state_q.pin_sync[2]) begin
      state_d.pin_lvl = state_q.pin_sync[2];
      pin_edge = state_q.pin_sync[2] & ~state_q.pin_lvl;
    end
    state_d.div = state_q.unit_en ? state_q.div + 16'h0001 : 16'h0000;

    // Write channels are taken independently, then committed together.
    if (s_axi_awvalid && state_q.aw_rdy) begin
      state_d.aw_full = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_q.w_rdy) begin
      state_d.w_full = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    if (state_q.aw_full && state_q.w_full && !state_q.bvalid) begin
      state_d.aw_full = 1'b0;
      state_d.w_full = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = RESP_OKAY;
      wv = state_q.w_data[15:0];
      if (state_q.aw_addr == OFF_MODE) begin
        state_d.mode = merge16(state_q.mode, state_q.w_data, state_q.w_strb);
      end else if (state_q.aw_addr == OFF_PRESC) begin
        state_d.prescale = merge16(state_q.prescale, state_q.w_data, state_q.w_strb);
      end else if (state_q.aw_addr == OFF_CMP) begin
        state_d.compare = CNT_W'(merge16(16'(state_q.compare), state_q.w_data, state_q.w_strb));
      end else if (state_q.aw_addr == OFF_CTRL) begin
        if (state_q.w_strb[0]) begin
          state_d.unit_en = wv[CTRL_UNIT_EN];
          state_d.out_en = wv[CTRL_OUT_EN];
          start = wv[CTRL_START];
          stop = wv[CTRL_STOP];
          if (!state_q.out_en) begin
            state_d.out_lvl = wv[CTRL_OUT_LVL];
          end
        end
      end else if (state_q.aw_addr == OFF_IRQ_CLR) begin
        if (state_q.w_strb[0]) begin
          state_d.irq_stat = state_q.irq_stat & ~wv[IRQ_N-1:0];
        end
      end else if (state_q.aw_addr == OFF_IRQ_EN) begin
        if (state_q.w_strb[0]) begin
          state_d.irq_en = wv[IRQ_N-1:0];
        end
      end else if (state_q.aw_addr == OFF_CNT || state_q.aw_addr == OFF_IRQ_STAT) begin
        state_d.bresp = RESP_OKAY;
      end else begin
        state_d.bresp = RESP_SLVERR;
      end
    end
    state_d.aw_rdy = !state_d.aw_full && !state_d.bvalid;
    state_d.w_rdy = !state_d.w_full && !state_d.bvalid;

    // Read channel answers one cycle after the address is taken.
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_q.ar_rdy) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = RESP_OKAY;
      state_d.rdata = 32'h00000000;
      if (s_axi_araddr == OFF_MODE) begin
        state_d.rdata[15:0] = state_q.mode;
      end else if (s_axi_araddr == OFF_PRESC) begin
        state_d.rdata[15:0] = state_q.prescale;
      end else if (s_axi_araddr == OFF_CMP) begin
        state_d.rdata[CNT_W-1:0] = state_q.compare;
      end else if (s_axi_araddr == OFF_CTRL) begin
        state_d.rdata[CTRL_UNIT_EN] = state_q.unit_en;
        state_d.rdata[CTRL_OUT_EN] = state_q.out_en;
        state_d.rdata[CTRL_OUT_LVL] = state_q.out_lvl;
        state_d.rdata[CTRL_RUNNING] = state_q.running;
      end else if (s_axi_araddr == OFF_CNT) begin
        state_d.rdata[CNT_W-1:0] = state_q.counter;
      end else if (s_axi_araddr == OFF_IRQ_STAT) begin
        state_d.rdata[IRQ_N-1:0] = state_q.irq_stat;
      end else if (s_axi_araddr == OFF_IRQ_EN) begin
        state_d.rdata[IRQ_N-1:0] = state_q.irq_en;
      end else if (s_axi_araddr == OFF_IRQ_CLR) begin
        state_d.rresp = RESP_OKAY;
      end else begin
        state_d.rresp = RESP_SLVERR;
      end
    end
    state_d.ar_rdy = !state_d.rvalid;

    // Operation clock and count clock selection.
    case (state_q.mode[MODE_CKS_HI:MODE_CKS_LO])
      2'h0: op_tick = presc_tick[0];
      2'h1: op_tick = presc_tick[2];
      2'h2: op_tick = presc_tick[1];
      default: op_tick = presc_tick[3];
    endcase
    cnt_tick = state_q.mode[MODE_CCS] ? pin_edge : op_tick;

    case (md)
      MD_INTERVAL, MD_EVENT, MD_ONECOUNT: mode_ok = 1'b1;
      MD_CAPTURE, MD_CAP_ONE: begin
        mode_ok = 1'b1;
        up_mode = 1'b1;
      end
      default: mode_ok = 1'b0;
    endcase

    // Counting.
    if (stop) begin
      state_d.running = 1'b0;
    end else if (start) begin
      if (!mode_ok) begin
        ev_bad = 1'b1;
      end else if (!state_q.running || (md == MD_ONECOUNT && opt)) begin
        state_d.running = 1'b1;
        state_d.counter = up_mode ? '0 : state_q.compare;
        if (!state_q.running && opt && (md == MD_INTERVAL || md == MD_CAPTURE)) begin
          ev_timer = 1'b1;
          toggle = 1'b1;
        end
      end
    end else if (state_q.running && state_q.unit_en) begin
      case (md)
        MD_INTERVAL, MD_EVENT: begin
          if (cnt_tick) begin
            if (state_q.counter == '0) begin
              state_d.counter = state_q.compare;
              ev_timer = 1'b1;
              toggle = (md == MD_INTERVAL);
            end else begin
              state_d.counter = state_q.counter - 1'b1;
            end
          end
        end
        MD_ONECOUNT: begin
          if (cnt_tick) begin
            if (state_q.counter == '0) begin
              ev_timer = 1'b1;
              toggle = 1'b1;
              state_d.running = 1'b0;
            end else begin
              state_d.counter = state_q.counter - 1'b1;
            end
          end
        end
        MD_CAPTURE: begin
          if (pin_edge) begin
            state_d.compare = state_q.counter;
            state_d.counter = '0;
            ev_timer = 1'b1;
          end else if (cnt_tick) begin
            state_d.counter = state_q.counter + 1'b1;
          end
        end
        MD_CAP_ONE: begin
          if (pin_edge) begin
            state_d.compare = state_q.counter;
            ev_timer = 1'b1;
            state_d.running = 1'b0;
          end else if (cnt_tick) begin
            state_d.counter = state_q.counter + 1'b1;
          end
        end
        default: state_d.running = 1'b0;
      endcase
    end

    // Output and interrupt; a new event wins over a clear in the same cycle.
    if (toggle && state_q.out_en) begin
      state_d.out_lvl = ~state_q.out_lvl;
    end
    state_d.irq_stat[IRQ_TIMER] = state_d.irq_stat[IRQ_TIMER] | ev_timer;
    state_d.irq_stat[IRQ_BAD_MODE] = state_d.irq_stat[IRQ_BAD_MODE] | ev_bad;
    state_d.irq = |(state_d.irq_stat & state_d.irq_en);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign s_axi_awready = state_q.aw_rdy;
  assign s_axi_wready = state_q.w_rdy;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = state_q.ar_rdy;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;
  assign timer_output = state_q.out_lvl;
  assign channel_interrupt = state_q.irq;

endmodule // tcm_top

// File: verification/tcm_props.sv
// Purpose: Port-level checks for the timer channel and its register bus.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to tcm_top at the foot of this file.
module tcm_props
  import tcm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Timer pins
  input wire logic timer_output,
  input wire logic channel_interrupt
);
  // ****************************************************************
  // Address tracking and checks
  // ****************************************************************
  logic [ADDR_W-1:0] aw_q;
  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && a <= OFF_IRQ_EN;
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) aw_q <= '0;
    else if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before it was taken");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write response late");
  chk_wr_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (mapped(aw_q) ? RESP_OKAY : RESP_SLVERR))
    else $error("wrong write response code");
  chk_rd_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rresp == (mapped($past(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR))
    else $error("wrong or late read response");
  chk_rd_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  chk_irq_fall: assert property ($past(aresetn) && $fell(channel_interrupt) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a register write");
  cov_irq: cover property ($rose(channel_interrupt));
  cov_slverr: cover property ($rose(s_axi_bvalid) && s_axi_bresp == RESP_SLVERR);
  cov_toggle: cover property ($changed(timer_output));
endmodule // tcm_props

bind tcm_top tcm_props #(.CNT_W(CNT_W)) chk_u (.*);

// File: verification/tb_timer_channel_mode_control.sv
// Purpose: Self-checking bench for the timer channel.
// Assumes: 50 ns clock, reset held for four cycles.
// Notes: Random values come from a fixed seed.
module tb_timer_channel_mode_control
  import tcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, timer_input_pin = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_output, channel_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  tcm_top #(.CNT_W(16)) dut_u (.*);
  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 2000) begin
      miscompares++;
      $display("MISMATCH at %0t: wait ran out", $time);
      summarize();
    end
  endtask
  // The bus tasks are entered just after a rising edge and sample the slave at the falling edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int n;
    n = 0;
    b = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      guard(n);
    end
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    int n;
    n = 0;
    v = 1'b0;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (!v) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      guard(n);
    end
    @(posedge aclk);
  endtask
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      guard(n);
    end while (channel_interrupt !== 1'b1);
    t = cyc;
    @(posedge aclk);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      timer_input_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      timer_input_pin <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] d, c1, c2;
    logic [1:0] r;
    logic [3:0] code;
    logic [3:0] cases [9];
    int t0, t1, k, cmp;
    bit si, pr, up, eo;
    void'($urandom(49702));
    cases = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc, 4'h2};
    if ($urandom_range(0, 1)) cases[8] = 4'ha;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 32; a += 4) begin
      axi_rd(8'(a), d, r);
      check(d, 32'h0);
      check(r, RESP_OKAY);
    end
    axi_rd(8'h20, d, r);
    check(d, 32'h0);
    check(r, RESP_SLVERR);
    axi_wr(8'h24, $urandom, r);
    check(r, RESP_SLVERR);
    d = $urandom;
    axi_wr(OFF_MODE, d, r);
    axi_rd(OFF_MODE, c1, r);
    check(c1, {16'h0, d[15:0]});
    cmp = $urandom_range(8, 12);
    axi_wr(OFF_PRESC, 32'h3210, r);
    axi_wr(OFF_CMP, cmp, r);
    axi_wr(OFF_IRQ_EN, 32'h1, r);
    for (int s = 0; s < 4; s++) begin
      axi_wr(OFF_MODE, s << 14, r);
      axi_wr(OFF_CTRL, 32'h3, r);
      for (int i = 0; i < 3; i++) begin
        t0 = t1;
        wait_irq(t1);
        axi_wr(OFF_IRQ_CLR, 32'h1, r);
      end
      check(t1 - t0, (cmp + 1) << {s[0], s[1]});
      axi_wr(OFF_CTRL, 32'h5, r);
    end
    axi_wr(OFF_CTRL, 32'h10, r);
    check(timer_output, 1'b1);
    axi_wr(OFF_CTRL, 32'h18, r);
    axi_wr(OFF_CTRL, 32'h08, r);
    check(timer_output, 1'b1);
    eo = 1'b1;
    axi_wr(OFF_PRESC, 32'h0, r);
    axi_wr(OFF_CMP, 32'd200, r);
    axi_wr(OFF_IRQ_CLR, 32'h3, r);
    for (int i = 0; i < 9; i++) begin
      code = cases[i];
      si = (code[3:1] == MD_INTERVAL || code[3:1] == MD_CAPTURE) && code[0];
      pr = i == 8;
      up = code[3:1] == MD_CAPTURE || code[3:1] == MD_CAP_ONE;
      axi_wr(OFF_MODE, {28'h0, code}, r);
      axi_wr(OFF_CTRL, 32'hb, r);
      axi_rd(OFF_CNT, c1, r);
      axi_wr(OFF_CTRL, 32'hb, r);
      axi_rd(OFF_CNT, c2, r);
      axi_rd(OFF_IRQ_STAT, d, r);
      check(d, {pr, si});
      check(channel_interrupt, si);
      eo ^= si;
      check(timer_output, eo);
      // A restart reloads the counter, so both reads land the same number of ticks after a start.
      check((pr || code == 4'h9) ? c2 == c1 : up == (c2 > c1), 1'b1);
      axi_wr(OFF_CTRL, 32'hd, r);
      axi_wr(OFF_IRQ_CLR, 32'h3, r);
    end
    axi_wr(OFF_MODE, 32'h1006, r);
    axi_wr(OFF_CMP, 32'h5, r);
    axi_wr(OFF_CTRL, 32'h3, r);
    k = $urandom_range(1, 5);
    pulses(k);
    axi_rd(OFF_CNT, d, r);
    check(d, 5 - k);
    pulses(6 - k);
    axi_rd(OFF_CNT, d, r);
    check(d, 32'h5);
    axi_rd(OFF_IRQ_STAT, d, r);
    check(d, 32'h1);
    check(channel_interrupt, 1'b1);
    axi_wr(OFF_IRQ_EN, 32'h0, r);
    check(channel_interrupt, 1'b0);
    axi_wr(OFF_IRQ_CLR, 32'h1, r);
    axi_rd(OFF_IRQ_STAT, d, r);
    check(d, 32'h0);
    // Pin edges come twelve clocks apart; the capture cycle restarts the count, so eleven ticks are held.
    axi_wr(OFF_CTRL, 32'h5, r);
    axi_wr(OFF_MODE, 32'h4, r);
    axi_wr(OFF_CTRL, 32'h3, r);
    pulses(2);
    axi_rd(OFF_CMP, d, r);
    check(d, 32'd11);
    summarize();
  end
endmodule // tb_timer_channel_mode_control
